// ---- verilog/acc_pkg.sv ----
// Purpose: shared constants for the analog comparator control block
// Assumes: classic wishbone slave with 32-bit data, word-aligned registers
// Notes: register offsets are byte addresses
package acc_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ACC_OFS_CTRL = 4'h0;
  localparam logic [3:0] ACC_OFS_IRQ_STAT = 4'h4;
  localparam logic [3:0] ACC_OFS_IRQ_MASK = 4'h8;
  localparam logic [3:0] ACC_OFS_SYS = 4'hC;
  // ----------------------------------------------------------------
  // control/status field positions
  // ----------------------------------------------------------------
  localparam int ACC_BIT_POWER_OFF = 7;
  localparam int ACC_BIT_REF_SEL = 6;
  localparam int ACC_BIT_RESULT = 5;
  localparam int ACC_BIT_FLAG = 4;
  localparam int ACC_BIT_IRQ_EN = 3;
  localparam int ACC_BIT_ROUTE = 2;
  localparam int ACC_BIT_MODE_HI = 1;
  localparam int ACC_BIT_MODE_LO = 0;
  // system register: global enable and timer capture enable
  localparam int ACC_BIT_GLOBAL_IE = 0;
  localparam int ACC_BIT_CAP_IE = 1;
  // irq status/mask: comparator event and capture event
  localparam int ACC_IRQ_CMP = 0;
  localparam int ACC_IRQ_CAP = 1;
  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  localparam logic [1:0] ACC_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] ACC_MODE_RESERVED = 2'h1;
  localparam logic [1:0] ACC_MODE_FALL = 2'h2;
  localparam logic [1:0] ACC_MODE_RISE = 2'h3;
endpackage

// ---- verilog/acc_edge_if.sv ----
// Purpose: carries the synchronised comparator sample between modules
// Assumes: single clock
// Notes: none
`timescale 1ns/1ps
interface acc_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ---- verilog/acc_sync.sv ----
// Purpose: two-flop synchroniser and edge detector for the comparator output
// Assumes: raw input may be asynchronous to clk_i
// Notes: edges show in the same cycle as the new level
`timescale 1ns/1ps
module acc_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // raw comparator output
  input wire logic raw_i,
  // synchronised view
  acc_edge_if.src edge_o
);
  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic [2:0] fill;
  } acc_sync_t;
  acc_sync_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.meta = raw_i;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync;
    // fill marks which stages hold a real sample since reset
    s_d.fill = {s_q.fill[1:0], 1'b1};
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign edge_o.level = s_q.sync;
  // no edge until prev holds a real sample: a comparator already high at
  // reset must not look like a rise against the cleared stages
  assign edge_o.rise = s_q.fill[2] & s_q.sync & ~s_q.prev;
  assign edge_o.fall = s_q.fill[2] & ~s_q.sync & s_q.prev;

  a_rise_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_o.rise |-> $past(raw_i, 2) && !$past(raw_i, 3))
    else $error("rise without a matching raw edge");

  a_fall_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    edge_o.fall |-> !$past(raw_i, 2) && $past(raw_i, 3))
    else $error("fall without a matching raw edge");
endmodule // acc_sync

// ---- verilog/acc_top.sv ----
// What this block does
// - result bit shows live comparator output.
// - power-off bit cuts comparator power; writable any time.
// - reference select with brownout enabled feeds fixed reference to positive input.
// - matching output event sets the event flag.
// - irq request only when flag, local enable and global enable set.
// - taking the vector clears the flag.
// - writing one clears the flag; zero leaves it.
// - route bit connects output to capture front end, else nothing.
// - capture interrupt from routed output needs capture irq enable at the timer; capture status on irq_o needs only its mask bit.
// - mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - read-modify-write writes a read one back and clears the flag.
// - comparator and capture interrupts are separate sources.
//
// Purpose: control and status logic around an analog comparator
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes: unmapped reads return zero and are acknowledged
`timescale 1ns/1ps
module acc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // analog core
  input wire logic cmp_raw_i,
  input wire logic brownout_enable_fuse_i,
  output logic comparator_power_off_o,
  output logic ref_select_o,
  // cpu and timer side
  input wire logic vector_taken_i,
  output logic cmp_irq_req_o,
  output logic capture_src_o,
  output logic capture_irq_gate_o,
  // combined interrupt
  output logic irq_o
);
  typedef struct packed {
    logic power_off;
    logic ref_sel;
    logic flag;
    logic irq_en;
    logic route;
    logic [1:0] mode;
    logic global_ie;
    logic cap_ie;
    logic [1:0] istat;
    logic [1:0] imask;
    logic ack;
    logic [31:0] rdata;
  } acc_state_t;

  acc_state_t s_q, s_d;
  acc_edge_if cmp_edge ();

  acc_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(cmp_raw_i),
    .edge_o(cmp_edge)
  );

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  logic cmp_event;
  logic cap_event;
  logic req;
  logic wr;
  logic rd;
  logic [7:0] ctrl_view;

  always_comb begin
    case (s_q.mode)
      acc_pkg::ACC_MODE_TOGGLE: cmp_event = cmp_edge.rise | cmp_edge.fall;
      acc_pkg::ACC_MODE_FALL: cmp_event = cmp_edge.fall;
      acc_pkg::ACC_MODE_RISE: cmp_event = cmp_edge.rise;
      default: cmp_event = 1'b0;
    endcase
  end

  // routed output edge, used only for the capture status bit
  assign cap_event = s_q.route & cmp_edge.rise;

  always_comb begin
    ctrl_view = '0;
    ctrl_view[acc_pkg::ACC_BIT_POWER_OFF] = s_q.power_off;
    ctrl_view[acc_pkg::ACC_BIT_REF_SEL] = s_q.ref_sel;
    ctrl_view[acc_pkg::ACC_BIT_RESULT] = cmp_edge.level;
    ctrl_view[acc_pkg::ACC_BIT_FLAG] = s_q.flag;
    ctrl_view[acc_pkg::ACC_BIT_IRQ_EN] = s_q.irq_en;
    ctrl_view[acc_pkg::ACC_BIT_ROUTE] = s_q.route;
    ctrl_view[acc_pkg::ACC_BIT_MODE_HI] = s_q.mode[1];
    ctrl_view[acc_pkg::ACC_BIT_MODE_LO] = s_q.mode[0];
  end

  assign req = cyc_i & stb_i & ~s_q.ack;
  assign wr = req & we_i;
  assign rd = req & ~we_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.ack = req;
    s_d.rdata = '0;
    if (rd) begin
      case (adr_i)
        acc_pkg::ACC_OFS_CTRL: s_d.rdata = {24'h000000, ctrl_view};
        acc_pkg::ACC_OFS_IRQ_STAT: s_d.rdata = {30'h0, s_q.istat};
        acc_pkg::ACC_OFS_IRQ_MASK: s_d.rdata = {30'h0, s_q.imask};
        acc_pkg::ACC_OFS_SYS: s_d.rdata = {30'h0, s_q.cap_ie, s_q.global_ie};
        default: s_d.rdata = '0;
      endcase
    end
    if (wr && sel_i[0]) begin
      case (adr_i)
        acc_pkg::ACC_OFS_CTRL: begin
          s_d.power_off = dat_i[acc_pkg::ACC_BIT_POWER_OFF];
          s_d.ref_sel = dat_i[acc_pkg::ACC_BIT_REF_SEL];
          s_d.irq_en = dat_i[acc_pkg::ACC_BIT_IRQ_EN];
          s_d.route = dat_i[acc_pkg::ACC_BIT_ROUTE];
          s_d.mode = {dat_i[acc_pkg::ACC_BIT_MODE_HI], dat_i[acc_pkg::ACC_BIT_MODE_LO]};
          // write one clears; written-back one clears too
          if (dat_i[acc_pkg::ACC_BIT_FLAG]) begin
            s_d.flag = 1'b0;
          end
        end
        acc_pkg::ACC_OFS_IRQ_STAT: s_d.istat = s_q.istat & ~dat_i[1:0];
        acc_pkg::ACC_OFS_IRQ_MASK: s_d.imask = dat_i[1:0];
        acc_pkg::ACC_OFS_SYS: begin
          s_d.global_ie = dat_i[acc_pkg::ACC_BIT_GLOBAL_IE];
          s_d.cap_ie = dat_i[acc_pkg::ACC_BIT_CAP_IE];
        end
        default: s_d.imask = s_q.imask;
      endcase
    end
    if (vector_taken_i) begin
      s_d.flag = 1'b0;
    end
    // event sets flag; set wins over clear
    if (cmp_event) begin
      s_d.flag = 1'b1;
      s_d.istat[acc_pkg::ACC_IRQ_CMP] = 1'b1;
    end
    if (cap_event) begin
      s_d.istat[acc_pkg::ACC_IRQ_CAP] = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dat_o = s_q.rdata;
  assign ack_o = s_q.ack;
  assign comparator_power_off_o = s_q.power_off;
  assign ref_select_o = s_q.ref_sel & brownout_enable_fuse_i;
  assign cmp_irq_req_o = s_q.flag & s_q.irq_en & s_q.global_ie;
  assign capture_src_o = s_q.route & cmp_edge.level;
  // capture irq needs its own enable
  assign capture_irq_gate_o = s_q.cap_ie;
  assign irq_o = |(s_q.istat & s_q.imask);

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // these watch registered state, so a write shows one edge after the
  // edge that took it; the bus checks lean on the single wait state

  a_irq_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_irq_req_o == (s_q.flag && s_q.irq_en && s_q.global_ie))
    else $error("irq request not gated by flag and enables");

  a_local_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.irq_en |-> !cmp_irq_req_o)
    else $error("irq request without local enable");

  a_global_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.global_ie |-> !cmp_irq_req_o)
    else $error("irq request without global enable");

  // matching event sets the flag next cycle
  a_event_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_event |=> s_q.flag)
    else $error("event did not set flag");

  // event also lands in irq status
  a_event_status: assert property (@(posedge clk_i) disable iff (rst_i)
    cmp_event |=> s_q.istat[acc_pkg::ACC_IRQ_CMP])
    else $error("event did not set comparator status");

  // vector take without event clears the flag
  a_vector_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    vector_taken_i && !cmp_event |=> !s_q.flag)
    else $error("vector take did not clear flag");

  a_vector_irq: assert property (@(posedge clk_i) disable iff (rst_i)
    vector_taken_i && !cmp_event |=> !cmp_irq_req_o)
    else $error("request stayed up after vector take");

  a_flag_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_i[0] && adr_i == acc_pkg::ACC_OFS_CTRL && dat_i[acc_pkg::ACC_BIT_FLAG] && !cmp_event |=> !s_q.flag)
    else $error("write one did not clear flag");

  a_flag_w0hold: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_i[0] && adr_i == acc_pkg::ACC_OFS_CTRL && !dat_i[acc_pkg::ACC_BIT_FLAG]
      && !vector_taken_i && s_q.flag |=> s_q.flag)
    else $error("write zero changed flag");

  // status bits clear on write of one
  a_status_w1c: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_i[0] && adr_i == acc_pkg::ACC_OFS_IRQ_STAT && dat_i[acc_pkg::ACC_IRQ_CMP] && !cmp_event
      |=> !s_q.istat[acc_pkg::ACC_IRQ_CMP])
    else $error("write one did not clear comparator status");

  a_reserved_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == acc_pkg::ACC_MODE_RESERVED |-> !cmp_event)
    else $error("reserved mode produced an event");

  a_rise_only: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == acc_pkg::ACC_MODE_RISE && !cmp_edge.rise |-> !cmp_event)
    else $error("rising mode flagged without a rise");

  a_fall_only: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == acc_pkg::ACC_MODE_FALL && !cmp_edge.fall |-> !cmp_event)
    else $error("falling mode flagged without a fall");

  a_toggle_any: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.mode == acc_pkg::ACC_MODE_TOGGLE && (cmp_edge.rise || cmp_edge.fall) |-> cmp_event)
    else $error("toggle mode missed an edge");

  a_power_off: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_i[0] && adr_i == acc_pkg::ACC_OFS_CTRL
      |=> comparator_power_off_o == $past(dat_i[acc_pkg::ACC_BIT_POWER_OFF]))
    else $error("power-off bit not written");

  a_power_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && sel_i[0] && adr_i == acc_pkg::ACC_OFS_CTRL) |=> $stable(comparator_power_off_o))
    else $error("power-off changed without a write");

  // no routing means no capture source
  a_route_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !s_q.route |-> !capture_src_o)
    else $error("capture source driven without routing");

  // routing passes the level straight on
  a_route_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    s_q.route |-> capture_src_o == cmp_edge.level)
    else $error("routed capture source differs from result");

  // routed rise lands in capture status
  a_capture_status: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_event |=> s_q.istat[acc_pkg::ACC_IRQ_CAP])
    else $error("routed rise did not set capture status");

  a_cap_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && sel_i[0] && adr_i == acc_pkg::ACC_OFS_SYS
      |=> capture_irq_gate_o == $past(dat_i[acc_pkg::ACC_BIT_CAP_IE]))
    else $error("capture irq enable not written");

  a_ref_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    !brownout_enable_fuse_i |-> !ref_select_o)
    else $error("reference selected without brownout enable");

  // bus answers one edge after taking a request
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    req |=> ack_o)
    else $error("request not answered next cycle");

  // one answer per request
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

  // read data is zero outside the answer
  a_read_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    !ack_o |-> dat_o == 32'h00000000)
    else $error("read data shown outside an answer");
endmodule // acc_top

// ---- verilog/acc_unused_placeholder_none.sv ----
// Purpose: intentionally empty
// Assumes: nothing
// Notes: nothing
`timescale 1ns/1ps

// ---- tb/acc_partner.sv ----
// Purpose: behavioural comparator core and timer capture front end
// Assumes: analog levels given in millivolts
// Notes: an unpowered core holds its output low
`timescale 1ns/1ps
module acc_partner (
  // clock
  input wire logic clk_i,
  // analog levels
  input wire logic [15:0] pos_mv_i,
  input wire logic [15:0] neg_mv_i,
  // controls from the block
  input wire logic power_off_i,
  input wire logic ref_select_i,
  input wire logic capture_src_i,
  input wire logic capture_irq_gate_i,
  // comparator output and capture count
  output logic cmp_raw_o,
  output logic [7:0] capture_cnt_o
);
  logic [15:0] pos_eff;
  logic cap_q = 1'b0;
  logic [7:0] cnt_q = 8'h00;
  assign capture_cnt_o = cnt_q;
  assign pos_eff = ref_select_i ? 16'h04C4 : pos_mv_i;
  assign cmp_raw_o = !power_off_i && (pos_eff > neg_mv_i);
  always @(posedge clk_i) begin
    cap_q <= capture_src_i;
    if (capture_src_i && !cap_q && capture_irq_gate_i) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
endmodule // acc_partner

// ---- tb/test_analog_comparator_control.sv ----
// Purpose: self-checking bench for the comparator control block
// Assumes: one-cycle wishbone answer, levels in millivolts
// Notes: random analog levels come from a fixed seed
`timescale 1ns/1ps
module test_analog_comparator_control;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [3:0] adr_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic fuse = 1'b0;
  logic vec = 1'b0;
  logic [15:0] pos = 16'h0;
  logic [15:0] neg = 16'h0;
  logic [31:0] dat_o, q;
  logic ack_o, raw, pwr, rsel, req, csrc, cgate, irq;
  logic [7:0] cnt, c0;
  int n_errors = 0;
  int check_count = 0;
  logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h3};
  logic [3:0] ofs [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  initial forever #4 clk_i = ~clk_i;
  acc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .cmp_raw_i(raw), .brownout_enable_fuse_i(fuse),
    .comparator_power_off_o(pwr), .ref_select_o(rsel), .vector_taken_i(vec), .cmp_irq_req_o(req),
    .capture_src_o(csrc), .capture_irq_gate_o(cgate), .irq_o(irq));
  acc_partner PM (.clk_i(clk_i), .pos_mv_i(pos), .neg_mv_i(neg), .power_off_i(pwr), .ref_select_i(rsel),
    .capture_src_i(csrc), .capture_irq_gate_i(cgate), .cmp_raw_o(raw), .capture_cnt_o(cnt));
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    // only the watchdog ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic lv(input logic [15:0] p, input logic [15:0] m);
    @(posedge clk_i);
    pos <= p;
    neg <= m;
    repeat (4) @(posedge clk_i);
  endtask
  function automatic logic hit(input logic [1:0] md, input logic up);
    return md == 2'h0 || md == {1'b1, up};
  endfunction
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    complete_run();
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'haac59ad5));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ofs[i]) begin
      bus(1'b0, ofs[i], 32'h0);
      chk("reset value", q, 32'h0);
    end
    repeat (6) begin
      lv(16'($urandom_range(3000)), 16'($urandom_range(3000)));
      bus(1'b0, 4'h0, 32'h0);
      chk("result", q[5], pos > neg);
    end
    bus(1'b1, 4'h0, 32'h40);
    lv(16'h0, 16'h03E8);
    for (int f = 0; f < 2; f++) begin
      fuse <= f[0];
      repeat (4) @(posedge clk_i);
      chk("ref select", rsel, f[0]);
      bus(1'b0, 4'h0, 32'h0);
      chk("ref result", q[5], f[0]);
    end
    lv(16'h0BB8, 16'h0);
    bus(1'b1, 4'h0, 32'h80);
    repeat (4) @(posedge clk_i);
    chk("power off", pwr, 1'b1);
    bus(1'b0, 4'h0, 32'h0);
    chk("off result", q[7:5], 3'h4);
    // irq enable low across power and mode changes
    foreach (modes[i]) begin
      for (int u = 0; u < 2; u++) begin
        lv(u ? 16'h0 : 16'h0BB8, 16'h0100);
        bus(1'b1, 4'h0, {26'h4, modes[i]});
        lv(u ? 16'h0BB8 : 16'h0, 16'h0100);
        bus(1'b0, 4'h0, 32'h0);
        chk("event flag", q[4], hit(modes[i], u[0]));
      end
    end
    // reserved mode flags nothing, irq enable still low
    bus(1'b1, 4'h0, 32'h11);
    lv(16'h0, 16'h0100);
    lv(16'h0BB8, 16'h0100);
    bus(1'b0, 4'h0, 32'h0);
    chk("reserved mode", q[4], 1'b0);
    bus(1'b1, 4'hC, 32'h1);
    bus(1'b1, 4'h0, 32'h18);
    lv(16'h0, 16'h0100);
    chk("irq request", req, 1'b1);
    bus(1'b1, 4'hC, 32'h0);
    chk("no global", req, 1'b0);
    bus(1'b1, 4'hC, 32'h1);
    bus(1'b1, 4'h0, 32'h0);
    chk("no local", req, 1'b0);
    bus(1'b1, 4'h0, 32'h08);
    chk("local on", req, 1'b1);
    @(posedge clk_i);
    vec <= 1'b1;
    @(posedge clk_i);
    vec <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("vector clear", req, 1'b0);
    lv(16'h0BB8, 16'h0100);
    bus(1'b1, 4'h0, 32'h08);
    bus(1'b0, 4'h0, 32'h0);
    chk("zero write", q[4], 1'b1);
    bus(1'b1, 4'h0, q | 32'h04);
    bus(1'b0, 4'h0, 32'h0);
    chk("rmw clears", q[4:2], 3'h3);
    bus(1'b1, 4'h0, 32'h04);
    c0 = cnt;
    lv(16'h0, 16'h0100);
    lv(16'h0BB8, 16'h0100);
    chk("capture src", csrc, 1'b1);
    chk("gated capture", cnt, c0);
    bus(1'b1, 4'hC, 32'h3);
    chk("capture gate", cgate, 1'b1);
    lv(16'h0, 16'h0100);
    lv(16'h0BB8, 16'h0100);
    chk("capture count", cnt, c0 + 8'h01);
    chk("cmp irq apart", req, 1'b0);
    bus(1'b0, 4'h4, 32'h0);
    chk("irq status", q[1:0], 2'h3);
    bus(1'b1, 4'h0, 32'h0);
    chk("route off", csrc, 1'b0);
    bus(1'b1, 4'h8, 32'h1);
    chk("irq unmasked", irq, 1'b1);
    bus(1'b1, 4'h8, 32'h0);
    chk("irq masked", irq, 1'b0);
    bus(1'b1, 4'h4, 32'h3);
    bus(1'b1, 4'h8, 32'h3);
    chk("irq cleared", irq, 1'b0);
    // mid-run reset with the comparator high: registers clear, no false edge
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    bus(1'b0, 4'h0, 32'h0);
    chk("reset ctrl", q, 32'h20);
    bus(1'b0, 4'h4, 32'h0);
    chk("reset status", q, 32'h0);
    bus(1'b0, 4'hC, 32'h0);
    chk("reset system", q, 32'h0);
    complete_run();
  end
endmodule // test_analog_comparator_control
